// file: rtl/eeprom_params.svh
// Offsets, field positions, reset values and timing counts of the EEPROM controller
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// I/O register offsets
`define NVM_OFS_GP0       6'h1e
`define NVM_OFS_CTRL      6'h1f
`define NVM_OFS_DATA      6'h20
`define NVM_OFS_ADDR_LO   6'h21
`define NVM_OFS_ADDR_HI   6'h22
`define NVM_OFS_GP1       6'h2a
`define NVM_OFS_GP2       6'h2b

// Control register field positions
`define NVM_CTRL_READ     0
`define NVM_CTRL_START    1
`define NVM_CTRL_ARM      2
`define NVM_CTRL_IRQEN    3
`define NVM_CTRL_MODE_LO  4
`define NVM_CTRL_MODE_HI  5

// Mode codes and reset values
`define NVM_MODE_ATOMIC   2'h0
`define NVM_MODE_ERASE    2'h1
`define NVM_MODE_WRITE    2'h2
`define NVM_MODE_RSVD     2'h3
`define NVM_REG_RESET     8'h00
`define NVM_ERASED_BYTE   8'hff

// Timing
`define NVM_CLK_PERIOD_NS   8
`define NVM_ATOMIC_TIME_NS  3400000
`define NVM_SPLIT_TIME_NS   1800000
`define NVM_ATOMIC_CYCLES   (`NVM_ATOMIC_TIME_NS / `NVM_CLK_PERIOD_NS)
`define NVM_SPLIT_CYCLES    (`NVM_SPLIT_TIME_NS / `NVM_CLK_PERIOD_NS)
`define NVM_ARM_CYCLES      3'h4
`define NVM_PROG_STALL      3'h2
`define NVM_READ_STALL      3'h4

`endif

// file: rtl/nvm_pkg.sv
// Types shared by the EEPROM controller files
package nvm_pkg;

  typedef logic [1:0] prog_mode_t;

  // One I/O register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_s;

  typedef enum logic {
    ST_IDLE,
    ST_PROGRAM
  } op_state_e;

endpackage : nvm_pkg

// file: rtl/nvm_byte_array.sv
// Byte-wide storage array with one write port and a registered read port
module nvm_byte_array #(
  parameter int DEPTH = 512,
  parameter int AW    = 9,
  parameter int DW    = 8
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [DEPTH];

  // Linear map: index equals byte address
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
    if (ce && re)
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : nvm_byte_array

// file: rtl/eeprom_access_controller.sv
// EEPROM access controller: I/O registers, arm/start sequence, timing, reads
`include "eeprom_params.svh"

// What this block does
// [R01] Nine-bit address, high byte bit zero only
// [R02] Address maps bytes linearly from zero
// [R03] Software loads address before any access
// [R04] Data register feeds writes, receives reads
// [R05] Mode field selects atomic, erase, write
// [R06] Mode writes ignored while busy
// [R07] Reset clears mode unless programming
// [R08] Level ready interrupt when enabled, idle
// [R09] Arm bit self-clears after four cycles
// [R10] Start only while arm still set
// [R11] Busy holds until programming time elapses
// [R12] Successful start stalls core two cycles
// [R13] Read fetches byte, stalls four cycles
// [R14] Busy refuses reads and address changes
// [R15] Software polls busy before reading
// [R16] Three plain storage registers, reset zero
// [R17] Reset lets running programming finish
// [R18] Write-only over unerased byte is undefined
// [R19] Counter times each mode's programming
module eeprom_access_controller #(
  parameter int unsigned ATOMIC_CYCLES = `NVM_ATOMIC_CYCLES,
  parameter int unsigned SPLIT_CYCLES  = `NVM_SPLIT_CYCLES,
  parameter int          CNT_W         = 20,
  parameter int          DEPTH         = 512,
  parameter int          AW            = 9
) (
  input  wire logic            clk,
  input  wire logic            ce,
  input  wire logic            por,
  input  wire logic            rst,
  input  wire nvm_pkg::io_req_s io_req,
  output logic      [7:0]      io_rdata,
  input  wire logic            global_irq_enable,
  output logic                 ready_irq,
  output logic                 cpu_stall,
  output logic                 program_busy
);
  import nvm_pkg::*;

  op_state_e        state_q;
  logic [CNT_W-1:0] op_cnt_q;
  prog_mode_t       mode_q;
  logic             irq_en_q;
  logic [2:0]       arm_cnt_q;
  logic [2:0]       stall_q;
  logic [AW-1:0]    addr_q;
  logic [7:0]       data_q;
  logic [7:0]       op_data_q;
  logic             rd_pend_q;
  logic [7:0]       gp0_q;
  logic [7:0]       gp1_q;
  logic [7:0]       gp2_q;
  logic [7:0]       rdata_q;
  logic [7:0]       mem_rdata;

  // Terminal count per mode, minus one since the load cycle counts too
  function automatic logic [CNT_W-1:0] op_cycles(input prog_mode_t m);
    if (m == `NVM_MODE_ATOMIC)
    begin
      return CNT_W'(ATOMIC_CYCLES - 1);
    end
    return CNT_W'(SPLIT_CYCLES - 1);
  endfunction : op_cycles

  // Address decode
  wire busy      = (state_q == ST_PROGRAM);
  wire wr_ok     = io_req.wr && !rst;
  wire wr_ctrl   = wr_ok && (io_req.addr == `NVM_OFS_CTRL);
  wire wr_data   = wr_ok && (io_req.addr == `NVM_OFS_DATA);
  wire wr_addr_l = wr_ok && (io_req.addr == `NVM_OFS_ADDR_LO);
  wire wr_addr_h = wr_ok && (io_req.addr == `NVM_OFS_ADDR_HI);
  wire wr_gp0    = wr_ok && (io_req.addr == `NVM_OFS_GP0);
  wire wr_gp1    = wr_ok && (io_req.addr == `NVM_OFS_GP1);
  wire wr_gp2    = wr_ok && (io_req.addr == `NVM_OFS_GP2);

  // Control register strobes; arm state is sampled before this write
  wire arm_q     = (arm_cnt_q != 3'h0);
  wire arm_wr    = wr_ctrl && io_req.wdata[`NVM_CTRL_ARM];
  wire mode_legal = (mode_q != `NVM_MODE_RSVD);
  wire start_go  = wr_ctrl && io_req.wdata[`NVM_CTRL_START] && arm_q   // R10
                   && !busy && mode_legal;
  wire read_go   = wr_ctrl && io_req.wdata[`NVM_CTRL_READ] && !busy    // R14
                   && !start_go;
  wire op_done   = busy && (op_cnt_q == '0);
  wire keep_on_rst = rst && !busy;  // Reset spares state a running job needs

  // Programming data: erase stores the blank value, others the latched byte
  wire       mem_we    = op_done;
  wire [7:0] mem_wdata = (mode_q == `NVM_MODE_ERASE) ? `NVM_ERASED_BYTE : op_data_q;  // R05 R18

  // Storage array; address is the byte index directly
  nvm_byte_array #(
    .DEPTH (DEPTH),
    .AW    (AW),
    .DW    (8)
  ) u_array (
    .clk     (clk),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (addr_q),    // R02
    .wdata   (mem_wdata),
    .re      (read_go),   // R13
    .raddr   (addr_q),
    .rdata_q (mem_rdata)
  );

  // Programming sequencer; system reset cannot abort it, only power-on can
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      state_q  <= ST_IDLE;
      op_cnt_q <= '0;
    end
    else if (ce)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start_go)
          begin
            state_q  <= ST_PROGRAM;              // R11
            op_cnt_q <= op_cycles(mode_q);       // R19 R05
          end
        end
        ST_PROGRAM:
        begin
          if (op_cnt_q == '0)
          begin
            state_q <= ST_IDLE;                  // R11
          end
          else
          begin
            op_cnt_q <= op_cnt_q - 1'b1;         // R17
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Mode field: frozen while busy, cleared by reset only when idle
  always_ff @(posedge clk)
  begin
    if (por || (ce && keep_on_rst))
    begin
      mode_q <= `NVM_MODE_ATOMIC;                // R07
    end
    else if (ce && wr_ctrl && !busy && !start_go)
    begin
      // A starting write keeps the mode that timed the job
      mode_q <= io_req.wdata[`NVM_CTRL_MODE_HI:`NVM_CTRL_MODE_LO];  // R06
    end
  end

  // Interrupt enable and the arm window
  always_ff @(posedge clk)
  begin
    if (por || rst)
    begin
      irq_en_q  <= 1'b0;
      arm_cnt_q <= 3'h0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
      begin
        irq_en_q <= io_req.wdata[`NVM_CTRL_IRQEN];
      end
      if (arm_wr)
      begin
        arm_cnt_q <= `NVM_ARM_CYCLES;            // R09
      end
      else if (arm_q)
      begin
        arm_cnt_q <= arm_cnt_q - 3'h1;           // R09
      end
    end
  end

  // Core stall counter; a start or a read reloads it
  always_ff @(posedge clk)
  begin
    if (por || rst)
    begin
      stall_q <= 3'h0;
    end
    else if (ce)
    begin
      if (start_go)
      begin
        stall_q <= `NVM_PROG_STALL;              // R12
      end
      else if (read_go)
      begin
        stall_q <= `NVM_READ_STALL;              // R13
      end
      else if (stall_q != 3'h0)
      begin
        stall_q <= stall_q - 3'h1;
      end
    end
  end

  // Address register: locked while busy so the running job keeps its target
  always_ff @(posedge clk)
  begin
    if (por || (ce && keep_on_rst))
    begin
      addr_q <= '0;
    end
    else if (ce && !busy)
    begin
      if (wr_addr_l)
      begin
        addr_q[7:0] <= io_req.wdata;             // R14
      end
      else if (wr_addr_h)
      begin
        addr_q[AW-1] <= io_req.wdata[0];         // R01
      end
    end
  end

  // Data register and the byte latched for programming
  always_ff @(posedge clk)
  begin
    if (por || (ce && keep_on_rst))
    begin
      data_q    <= `NVM_REG_RESET;
      op_data_q <= `NVM_REG_RESET;
      rd_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      rd_pend_q <= read_go;
      if (rd_pend_q)
      begin
        data_q <= mem_rdata;                     // R04
      end
      else if (wr_data)
      begin
        data_q <= io_req.wdata;                  // R04
      end
      if (start_go)
      begin
        op_data_q <= data_q;                     // R04
      end
    end
  end

  // General storage, no side effects
  always_ff @(posedge clk)
  begin
    if (por || rst)
    begin
      gp0_q <= `NVM_REG_RESET;                   // R16
      gp1_q <= `NVM_REG_RESET;
      gp2_q <= `NVM_REG_RESET;
    end
    else if (ce)
    begin
      gp0_q <= wr_gp0 ? io_req.wdata : gp0_q;
      gp1_q <= wr_gp1 ? io_req.wdata : gp1_q;
      gp2_q <= wr_gp2 ? io_req.wdata : gp2_q;
    end
  end

  // Read mux; the read strobe always reads back zero
  wire [7:0] ctrl_view = {2'h0, mode_q, irq_en_q, arm_q, busy, 1'b0};
  wire [7:0] addr_hi_view = {7'h00, addr_q[AW-1]};   // R01
  logic [7:0] rd_mux;
  always_comb
  begin
    case (io_req.addr)
      `NVM_OFS_GP0:     rd_mux = gp0_q;
      `NVM_OFS_CTRL:    rd_mux = ctrl_view;
      `NVM_OFS_DATA:    rd_mux = data_q;
      `NVM_OFS_ADDR_LO: rd_mux = addr_q[7:0];
      `NVM_OFS_ADDR_HI: rd_mux = addr_hi_view;
      `NVM_OFS_GP1:     rd_mux = gp1_q;
      `NVM_OFS_GP2:     rd_mux = gp2_q;
      default:          rd_mux = 8'h00;
    endcase
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      rdata_q <= 8'h00;
    end
    else if (ce && io_req.rd)
    begin
      rdata_q <= rd_mux;
    end
  end

  // Outputs; the interrupt is a level, held low while busy or while either enable is clear
  assign io_rdata     = rdata_q;
  assign ready_irq    = irq_en_q && global_irq_enable && !busy;   // R08
  assign cpu_stall    = (stall_q != 3'h0);
  assign program_busy = busy;

  // Checks; a low clock enable freezes time, so it suspends them
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (por || !ce);

  addr_high_zero_a: assert property (  // R01
    (io_req.rd && io_req.addr == `NVM_OFS_ADDR_HI) |=> io_rdata[7:1] == 7'h00)
    else $error("high address byte shows set upper bits");

  arm_expiry_a: assert property (  // R09
    arm_wr ##1 (!arm_wr && !rst)[*4] |-> arm_q ##1 !arm_q)
    else $error("arm bit not cleared after four cycles");

  start_busy_a: assert property (  // R10
    start_go |=> busy && mode_q == $past(mode_q))
    else $error("accepted start did not raise busy");

  no_arm_start_a: assert property (  // R10
    (wr_ctrl && io_req.wdata[`NVM_CTRL_START] && !arm_q && !busy) |=> !busy)
    else $error("start without arm took effect");

  prog_stall_a: assert property (  // R12
    start_go |=> cpu_stall[*2] ##1 !cpu_stall)
    else $error("programming stall is not two cycles");

  read_stall_a: assert property (  // R13
    read_go |=> cpu_stall[*4] ##1 !cpu_stall)
    else $error("read stall is not four cycles");

  read_data_a: assert property (  // R04
    read_go ##1 !wr_data |=> data_q == $past(mem_rdata))
    else $error("read byte not loaded into data register");

  mode_frozen_a: assert property (  // R06
    busy |=> $stable(mode_q))
    else $error("mode changed while busy");

  addr_locked_a: assert property (  // R14
    busy |=> $stable(addr_q))
    else $error("address changed while busy");

  busy_no_irq_a: assert property (  // R08
    busy |-> !ready_irq)
    else $error("ready interrupt raised while busy");

  reset_mode_a: assert property (  // R07
    (rst && !busy) |=> mode_q == `NVM_MODE_ATOMIC)
    else $error("idle reset did not clear mode");

  reset_keeps_job_a: assert property (  // R17
    (rst && busy && op_cnt_q != '0) |=> busy)
    else $error("reset aborted a running programming job");

  gp_reset_a: assert property (  // R16
    rst |=> gp0_q == 8'h00 && gp1_q == 8'h00 && gp2_q == 8'h00)
    else $error("storage registers not cleared by reset");

  atomic_start_c: cover property (start_go && mode_q == `NVM_MODE_ATOMIC);
  erase_done_c:   cover property (op_done && mode_q == `NVM_MODE_ERASE);
  read_c:         cover property (read_go);
  irq_c:          cover property (ready_irq);

endmodule : eeprom_access_controller

// file: test/core_model.sv
// Core-side model: issues I/O register accesses and honours the stall
module core_model (
  input  wire logic           clk,
  input  wire logic           cpu_stall,
  input  wire logic           program_busy,
  input  wire logic     [7:0] io_rdata,
  output nvm_pkg::io_req_s    io_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_pkg::*;

  initial io_req = '0;

  // One bus cycle; a pending access sits idle while the core is held
  task automatic cyc(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
    #1;
    if ((w | r) && cpu_stall === 1'b1)
    begin
      io_req = '0;
      while (cpu_stall === 1'b1)
      begin
        @(posedge clk);
        #1;
      end
    end
    io_req = '{w, r, a, d};
    @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 6'h00, 8'h00);
  endtask : idle

  // Read data lands one edge later and holds until the next read
  task automatic rdreg(input logic [5:0] a, output logic [7:0] d);
    cyc(1'b0, 1'b1, a, 8'h00);
    idle(1);
    d = io_rdata;
  endtask : rdreg

  // Poll busy before any array access, bounded
  task automatic wait_idle();
    int k;
    k = 0;
    do
    begin
      idle(1);
      k++;
    end
    while (program_busy !== 1'b0 && k < 200);
  endtask : wait_idle
endmodule : core_model

// file: test/tb.sv
// Self-checking bench for the EEPROM access controller
`include "eeprom_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import nvm_pkg::*;
  localparam int AT = 20;
  localparam int SP = 10;
  logic       clk, ce, por, rst, gie, ready_irq, cpu_stall, program_busy;
  io_req_s    io_req;
  logic [7:0] io_rdata, v, r;
  logic [8:0] a;
  logic [5:0] ofs [5];
  logic [7:0] msk [5];
  logic [7:0] mem_m [512];
  int         mismatches, n_compared, n_stall, n_busy, cycles;
  int         seed = 32'h6211;

  eeprom_access_controller #(.ATOMIC_CYCLES(AT), .SPLIT_CYCLES(SP)) dut_u (
    .clk(clk), .ce(ce), .por(por), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_enable(gie), .ready_irq(ready_irq), .cpu_stall(cpu_stall),
    .program_busy(program_busy));
  core_model core_u (.clk(clk), .cpu_stall(cpu_stall), .program_busy(program_busy),
    .io_rdata(io_rdata), .io_req(io_req));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Stall and busy cycles counted mid-cycle, away from the edges
  always @(negedge clk)
  begin
    n_stall += (cpu_stall === 1'b1);
    n_busy += (program_busy === 1'b1);
  end

  // Hang guard, far above the expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chkn

  // Busy length per mode; late or reserved starts never run
  function automatic int busy_len(input logic [1:0] m, input int gap);
    if (gap > 4 || m == 2'h3)
      return 0;
    return (m == 2'h0) ? AT : SP;
  endfunction : busy_len

  function automatic logic [7:0] exp_byte(input logic [1:0] m, input logic [7:0] d);
    return (m == 2'h1) ? 8'hff : d;
  endfunction : exp_byte

  // Program one byte: arm, start gap cycles later, then disturb the job
  task automatic prog(input logic [1:0] m, input logic [8:0] pa, input logic [7:0] d,
                      input int gap, input int poke);
    int n;
    n = busy_len(m, gap);
    gie <= 1'($random(seed));
    core_u.wait_idle();
    core_u.wr(`NVM_OFS_ADDR_HI, {7'h0, pa[8]});
    core_u.wr(`NVM_OFS_ADDR_LO, pa[7:0]);
    core_u.wr(`NVM_OFS_DATA, d);
    core_u.wr(`NVM_OFS_CTRL, {2'h0, m, 4'h8});
    core_u.wr(`NVM_OFS_CTRL, {2'h0, m, 4'hc});
    core_u.idle(gap - 1);
    n_stall = 0;
    n_busy = 0;
    core_u.wr(`NVM_OFS_CTRL, {2'h0, m, 4'ha});
    if (poke == 1)
    begin
      core_u.idle(1);
      chk8("irq_busy", 8'h00, {7'h0, ready_irq});
      core_u.wr(`NVM_OFS_ADDR_LO, ~pa[7:0]);
      core_u.wr(`NVM_OFS_CTRL, 8'h29);
    end
    else if (poke == 2)
    begin
      core_u.idle(3);
      rst <= 1'b1;
      core_u.idle(1);
      rst <= 1'b0;
    end
    else if (poke == 3)
    begin
      // Clock enable low freezes the job for five edges
      core_u.idle(3);
      ce <= 1'b0;
      core_u.idle(5);
      ce <= 1'b1;
    end
    core_u.wait_idle();
    chkn("stall", (n == 0) ? 0 : 2, n_stall);
    chkn("busy", n + ((poke == 3) ? 5 : 0), n_busy);
    if (n > 0)
      mem_m[pa] = exp_byte(m, d);
    core_u.rdreg(`NVM_OFS_CTRL, v);
    chk8("ctrl", {2'h0, m, (poke == 2) ? 4'h0 : 4'h8}, v);
    chk8("irq", {7'h0, gie & (poke != 2)}, {7'h0, ready_irq});
    core_u.rdreg(`NVM_OFS_ADDR_LO, v);
    chk8("addr_lo", pa[7:0], v);
  endtask : prog

  // Read one byte back through the read strobe
  task automatic rd_ee(input logic [8:0] pa);
    core_u.wait_idle();
    core_u.wr(`NVM_OFS_ADDR_HI, {7'h0, pa[8]});
    core_u.wr(`NVM_OFS_ADDR_LO, pa[7:0]);
    n_stall = 0;
    core_u.wr(`NVM_OFS_CTRL, 8'h01);
    core_u.idle(6);
    chkn("rd_stall", 4, n_stall);
    core_u.rdreg(`NVM_OFS_DATA, v);
    chk8("rd_data", mem_m[pa], v);
  endtask : rd_ee

  initial
  begin
    ce = 1'b1;
    por = 1'b1;
    rst = 1'b1;
    gie = 1'b0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    ofs = '{`NVM_OFS_GP0, `NVM_OFS_GP1, `NVM_OFS_GP2, 6'h23, `NVM_OFS_ADDR_HI};
    msk = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h01};
    repeat (5) @(posedge clk);
    por <= 1'b0;
    rst <= 1'b0;
    core_u.rdreg(`NVM_OFS_CTRL, v);
    chk8("ctrl_reset", 8'h00, v);
    // Plain registers, unmapped offset and the one-bit high address
    for (int i = 0; i < 5; i++)
    begin
      core_u.rdreg(ofs[i], v);
      chk8("reset_val", 8'h00, v);
      r = 8'($random(seed));
      core_u.wr(ofs[i], r);
      core_u.rdreg(ofs[i], v);
      chk8("reg_rw", r & msk[i], v);
    end
    a = 9'($random(seed));
    prog(2'h1, a, 8'h00, 4, 2);
    rd_ee(a);
    r = 8'($random(seed));
    prog(2'h2, a, r, 4, 3);
    rd_ee(a);
    r = 8'($random(seed));
    prog(2'h0, 9'h1ff, r, 4, 1);
    rd_ee(9'h1ff);
    prog(2'h3, a, 8'h5a, 4, 0);
    prog(2'h0, a, 8'h5a, 5, 0);
    rd_ee(a);
    results();
  end
endmodule : tb
